/* logic/scr_pkg.sv */
// Package for the scaler control and status register bank.
// Assumes a single system clock and a register access port that delivers
// decoded word offsets within the module's register space.
package scr_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [15:0] OFS_CTRL_SET   = 16'h110A;
  localparam logic [15:0] OFS_CTRL_CLR   = 16'h110C;
  localparam logic [15:0] OFS_STATUS     = 16'h110E;
  localparam logic [15:0] OFS_SLOT       = 16'h1110;
  localparam logic [15:0] OFS_IRQ_LEVEL  = 16'h1112;
  localparam logic [15:0] OFS_IRQ_VECTOR = 16'h1114;
  localparam logic [15:0] OFS_RELOC_HIGH = 16'h1116;
  localparam logic [15:0] OFS_RELOC_LOW  = 16'h1118;
  localparam logic [15:0] OFS_RELOC_SEL  = 16'h111A;
  localparam logic [15:0] OFS_BCAST      = 16'h111C;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int          CTRL_BITS         = 8;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [7:0]  CTRL_BUS_ERR_MASK = 8'h10;
  localparam int          ST_HAS_DATA       = 0;
  localparam int          ST_ALMOST_FULL    = 1;
  localparam int          ST_FULL           = 2;
  localparam int          ST_CHAIN_DATA     = 3;
  localparam int          ST_CHAIN_BUSY     = 4;
  localparam int          ST_TERM_ON        = 5;
  localparam int          ST_TERM_OFF       = 6;
  localparam int          ST_BUS_ERR        = 7;
  localparam int          SLOT_BITS         = 5;
  localparam logic [4:0]  SLOT_RESET        = 5'h1F;
  localparam int          IRQ_LEVEL_BITS    = 3;
  localparam logic [2:0]  IRQ_LEVEL_RESET   = 3'h0;
  localparam logic [7:0]  IRQ_VECTOR_RESET  = 8'hDD;
  localparam logic [7:0]  RELOC_RESET       = 8'h00;
  localparam logic [7:0]  BCAST_RESET       = 8'hAA;
  localparam logic [7:0]  GEO_ADDR_MOD      = 8'h2F;

  // Buffer capacity figures, in 32-bit words.
  localparam int          BUF_CAPACITY      = 32768;
  localparam int          BUF_FULL_MARGIN   = 33;
  localparam logic [15:0] ALMOST_FULL_RESET = 16'h0040;

  // Access sequencing of the register port.
  typedef enum logic [1:0] {
    SCR_IDLE,
    SCR_ACK,
    SCR_HOLD
  } scr_acc_type;

endpackage : scr_pkg

/* logic/scr_regs.sv */
// Control and status register bank of a 32-channel latching scaler.
// Assumes the bus interface decodes the module base address upstream,
// presents a word offset with one-cycle write or read strobes, and that
// all status inputs are synchronous to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none

module scr_regs #(
  parameter bit HAS_AUX_CONNECTOR = 1'b0,
  parameter bit HAS_EVENT_BUFFER  = 1'b1,
  parameter int BUF_COUNT_BITS    = 16
) (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_i,
  // Register access port.
  input  wire logic [15:0]               reg_offset_i,
  input  wire logic                      reg_write_i,
  input  wire logic                      reg_read_i,
  input  wire logic                      reg_is_d16_i,
  input  wire logic [15:0]               reg_wdata_i,
  output logic      [15:0]               reg_rdata_o,
  output logic                           reg_ack_o,
  // Interrupt acknowledge cycle.
  input  wire logic                      irq_ack_i,
  output logic      [7:0]                irq_vector_o,
  output logic      [2:0]                irq_level_o,
  output logic                           irq_request_o,
  // Status sources.
  input  wire logic [BUF_COUNT_BITS-1:0] buf_word_count_i,
  input  wire logic                      buf_has_data_flag_i,
  input  wire logic [15:0]               almost_full_level_i,
  input  wire logic                      chain_ready_i,
  input  wire logic                      chain_busy_i,
  input  wire logic                      own_busy_i,
  input  wire logic                      term_all_on_i,
  input  wire logic                      term_all_off_i,
  input  wire logic                      bus_error_event_i,
  input  wire logic [4:0]                aux_slot_connector_i,
  input  wire logic [4:0]                rotary_base_i,
  // Control outputs.
  output logic      [7:0]                control_o,
  output logic                           bus_error_allow_o,
  output logic      [4:0]                slot_number_o,
  output logic      [15:0]               relocated_base_o,
  output logic                           relocation_on_o,
  output logic      [7:0]                broadcast_address_o,
  output logic      [15:0]               active_base_o,
  output logic                           clear_data_o,
  output logic                           clear_buffer_o,
  output logic                           module_clear_o
);

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------

  // Address match helper, used for writes and reads alike.
  function automatic logic hit(input logic [15:0] ofs, input logic [15:0] want);
    hit = (ofs == want);
  endfunction : hit

  localparam int FULL_WORDS = scr_pkg::BUF_CAPACITY - scr_pkg::BUF_FULL_MARGIN;

  logic        wr_set, wr_clr, wr_slot, wr_bcast, rd_status;
  logic        slot_writable;
  logic [7:0]  ctrl_r;
  logic [4:0]  slot_r;
  logic [2:0]  irq_level_r;
  logic [7:0]  irq_vector_r;
  logic [7:0]  reloc_high_r;
  logic [7:0]  reloc_low_r;
  logic        reloc_sel_r;
  logic [7:0]  bcast_r;
  logic        bus_err_r;
  logic [7:0]  status_now;
  logic        almost_full_now;

  assign slot_writable = !HAS_AUX_CONNECTOR;
  // Aliases are only honoured for 16-bit cycles.
  assign wr_set    = reg_write_i && reg_is_d16_i
                     && hit(reg_offset_i, scr_pkg::OFS_CTRL_SET);
  assign wr_clr    = reg_write_i && reg_is_d16_i
                     && hit(reg_offset_i, scr_pkg::OFS_CTRL_CLR);
  assign wr_slot   = reg_write_i && slot_writable
                     && hit(reg_offset_i, scr_pkg::OFS_SLOT);
  assign wr_bcast  = reg_write_i && hit(reg_offset_i, scr_pkg::OFS_BCAST);
  assign rd_status = reg_read_i && hit(reg_offset_i, scr_pkg::OFS_STATUS);

  // ------------------------------------------------------------------
  // Control register with set and clear aliases
  // ------------------------------------------------------------------

  // Set aliasing ORs ones in; clear aliasing masks ones out. Bus-error
  // enable falls out as one bit of the same mask arithmetic.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_r <= scr_pkg::CTRL_RESET;
    end else if (wr_set) begin
      ctrl_r <= ctrl_r | reg_wdata_i[7:0];
    end else if (wr_clr) begin
      ctrl_r <= ctrl_r & ~reg_wdata_i[7:0];
    end
  end

  // ------------------------------------------------------------------
  // Status flags
  // ------------------------------------------------------------------

  // The level is owned by a register outside this bank, whose reset value
  // is scr_pkg::ALMOST_FULL_RESET words.
  assign almost_full_now = ({16'h0000, buf_word_count_i} >= {16'h0000, almost_full_level_i});

  // Current-cycle status; the bus-error flag is folded in so that an
  // event in the read cycle itself is still reported.
  always_comb begin
    status_now = 8'h00;
    status_now[scr_pkg::ST_HAS_DATA]    = buf_has_data_flag_i;
    status_now[scr_pkg::ST_ALMOST_FULL] = almost_full_now;
    status_now[scr_pkg::ST_FULL]        =
      (32'(buf_word_count_i) >= 32'(FULL_WORDS));
    status_now[scr_pkg::ST_CHAIN_DATA]  = chain_ready_i;
    status_now[scr_pkg::ST_CHAIN_BUSY]  = chain_busy_i | own_busy_i;
    status_now[scr_pkg::ST_TERM_ON]     = term_all_on_i & ~term_all_off_i;
    status_now[scr_pkg::ST_TERM_OFF]    = term_all_off_i & ~term_all_on_i;
    status_now[scr_pkg::ST_BUS_ERR]     = bus_err_r | bus_error_event_i;
  end

  // Sticky bus-error flag: a new error wins over the clear of a read.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      bus_err_r <= 1'b0;
    end else if (bus_error_event_i) begin
      bus_err_r <= 1'b1;
    end else if (rd_status) begin
      bus_err_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Slot, interrupt, relocation and broadcast registers
  // ------------------------------------------------------------------

  // Writable slot number on plain boards; aux boards read the connector.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      slot_r <= scr_pkg::SLOT_RESET;
    end else if (wr_slot) begin
      slot_r <= reg_wdata_i[4:0];
    end
  end

  // Plain read/write registers.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_level_r  <= scr_pkg::IRQ_LEVEL_RESET;
      irq_vector_r <= scr_pkg::IRQ_VECTOR_RESET;
      reloc_high_r <= scr_pkg::RELOC_RESET;
      reloc_low_r  <= scr_pkg::RELOC_RESET;
      reloc_sel_r  <= 1'b0;
      bcast_r      <= scr_pkg::BCAST_RESET;
    end else if (reg_write_i) begin
      if (hit(reg_offset_i, scr_pkg::OFS_IRQ_LEVEL)) begin
        irq_level_r <= reg_wdata_i[2:0];
      end
      if (hit(reg_offset_i, scr_pkg::OFS_IRQ_VECTOR)) begin
        irq_vector_r <= reg_wdata_i[7:0];
      end
      if (hit(reg_offset_i, scr_pkg::OFS_RELOC_HIGH)) begin
        reloc_high_r <= reg_wdata_i[7:0];
      end
      if (hit(reg_offset_i, scr_pkg::OFS_RELOC_LOW)) begin
        reloc_low_r <= reg_wdata_i[7:0];
      end
      if (hit(reg_offset_i, scr_pkg::OFS_RELOC_SEL)) begin
        reloc_sel_r <= reg_wdata_i[0];
      end
      if (wr_bcast) begin
        bcast_r <= reg_wdata_i[7:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // Read mux and acknowledge
  // ------------------------------------------------------------------

  // Read data and acknowledge are registered. A slot write on an aux
  // board is simply never acknowledged, so the master times out.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o   <= 1'b0;
    end else begin
      reg_ack_o <= (reg_read_i || reg_write_i)
                   && !(reg_write_i && !slot_writable
                        && hit(reg_offset_i, scr_pkg::OFS_SLOT));
      if (irq_ack_i) begin
        reg_rdata_o <= {8'h00, irq_vector_r};
      end else if (reg_read_i) begin
        case (reg_offset_i)
          scr_pkg::OFS_STATUS:     reg_rdata_o <= {8'h00, status_now};
          scr_pkg::OFS_SLOT:       reg_rdata_o <= {11'h0, slot_number_o};
          scr_pkg::OFS_IRQ_LEVEL:  reg_rdata_o <= {13'h0, irq_level_r};
          scr_pkg::OFS_IRQ_VECTOR: reg_rdata_o <= {8'h00, irq_vector_r};
          scr_pkg::OFS_RELOC_HIGH: reg_rdata_o <= {8'h00, reloc_high_r};
          scr_pkg::OFS_RELOC_LOW:  reg_rdata_o <= {8'h00, reloc_low_r};
          scr_pkg::OFS_RELOC_SEL:  reg_rdata_o <= {15'h0, reloc_sel_r};
          scr_pkg::OFS_BCAST:      reg_rdata_o <= {8'h00, bcast_r};
          default:                 reg_rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs and clear strobes
  // ------------------------------------------------------------------

  // Registered copies of control state; the interrupt request rises on
  // reaching the almost-full level when a non-zero level is set.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      control_o           <= scr_pkg::CTRL_RESET;
      bus_error_allow_o   <= 1'b0;
      slot_number_o       <= scr_pkg::SLOT_RESET;
      relocated_base_o    <= 16'h0000;
      relocation_on_o     <= 1'b0;
      broadcast_address_o <= scr_pkg::BCAST_RESET;
      active_base_o       <= 16'h0000;
      irq_vector_o        <= scr_pkg::IRQ_VECTOR_RESET;
      irq_level_o         <= scr_pkg::IRQ_LEVEL_RESET;
      irq_request_o       <= 1'b0;
    end else begin
      control_o           <= ctrl_r;
      bus_error_allow_o   <= |(ctrl_r & scr_pkg::CTRL_BUS_ERR_MASK);
      slot_number_o       <= HAS_AUX_CONNECTOR ? aux_slot_connector_i : slot_r;
      relocated_base_o    <= {reloc_high_r, reloc_low_r};
      relocation_on_o     <= reloc_sel_r;
      broadcast_address_o <= bcast_r;
      // Only one base decodes at a time, so the old one goes dead.
      active_base_o       <= reloc_sel_r ? {reloc_high_r, reloc_low_r}
                                         : {rotary_base_i, 11'h0};
      irq_vector_o        <= irq_vector_r;
      irq_level_o         <= irq_level_r;
      irq_request_o       <= (irq_level_r != scr_pkg::IRQ_LEVEL_RESET)
                             && almost_full_now;
    end
  end

  // One-cycle clear strobes for the datapath outside this bank.
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clear_data_o   <= 1'b0;
      clear_buffer_o <= 1'b0;
      module_clear_o <= 1'b0;
    end else begin
      clear_data_o   <= wr_set || wr_clr || wr_bcast || wr_slot;
      clear_buffer_o <= wr_set || wr_clr || wr_slot
                        || (wr_bcast && HAS_EVENT_BUFFER);
      module_clear_o <= wr_slot;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------

  sequence set_write_s;
    wr_set;
  endsequence

  set_alias_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    set_write_s |=> ((ctrl_r & $past(reg_wdata_i[7:0])) == $past(reg_wdata_i[7:0])))
    else $error("set alias did not set written bits");

  clr_alias_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_clr |=> ((ctrl_r & $past(reg_wdata_i[7:0])) == 8'h00))
    else $error("clear alias did not clear written bits");

  alias_clears_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_set || wr_clr) |=> (clear_data_o && clear_buffer_o))
    else $error("alias write did not clear datapath");

  berr_read_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_status && !bus_error_event_i) |=> !bus_err_r)
    else $error("bus error flag survived status read");

  berr_set_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    bus_error_event_i |=> bus_err_r)
    else $error("bus error flag not set");

  slot_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_slot |=> module_clear_o ##1 !module_clear_o || $past(wr_slot))
    else $error("slot write did not clear module");

  aux_noack_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (HAS_AUX_CONNECTOR && reg_write_i && !reg_read_i
     && hit(reg_offset_i, scr_pkg::OFS_SLOT)) |=> !reg_ack_o)
    else $error("aux slot write acknowledged");

  irq_level_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (irq_level_r == 3'h0) |=> !irq_request_o)
    else $error("interrupt with level zero");

  irq_af_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (almost_full_now && irq_level_r != 3'h0) |=> irq_request_o)
    else $error("almost full did not request interrupt");

  vector_ack_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    irq_ack_i |=> (reg_rdata_o[7:0] == $past(irq_vector_r)))
    else $error("vector not driven on acknowledge");

  bcast_clr_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    wr_bcast |=> clear_data_o)
    else $error("broadcast write did not clear counters");

  bus_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_clr && reg_wdata_i[7:0] == scr_pkg::CTRL_BUS_ERR_MASK)
    |=> (ctrl_r == ($past(ctrl_r) & ~scr_pkg::CTRL_BUS_ERR_MASK)))
    else $error("bus error mask touched other control bits");

  narrow_alias_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (reg_write_i && !reg_is_d16_i && hit(reg_offset_i, scr_pkg::OFS_CTRL_SET))
    |=> $stable(ctrl_r))
    else $error("alias honoured without a 16-bit cycle");

  status_data_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_status && !irq_ack_i)
    |=> (reg_rdata_o[scr_pkg::ST_HAS_DATA] == $past(buf_has_data_flag_i)))
    else $error("data ready status does not follow buffer");

  status_full_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_status && !irq_ack_i && 32'(buf_word_count_i) >= 32'(FULL_WORDS))
    |=> reg_rdata_o[scr_pkg::ST_FULL])
    else $error("full status missing at capacity");

  status_busy_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (rd_status && !irq_ack_i)
    |=> (reg_rdata_o[scr_pkg::ST_CHAIN_BUSY] == $past(chain_busy_i || own_busy_i)))
    else $error("busy status does not follow busy lines");

  aux_slot_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    HAS_AUX_CONNECTOR |=> (slot_number_o == $past(aux_slot_connector_i)))
    else $error("slot number not taken from connector");

  reloc_high_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (reg_write_i && hit(reg_offset_i, scr_pkg::OFS_RELOC_HIGH))
    |=> ##1 (relocated_base_o[15:8] == $past(reg_wdata_i[7:0], 2)))
    else $error("upper relocation bits not stored");

  reloc_pick_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (reg_write_i && hit(reg_offset_i, scr_pkg::OFS_RELOC_SEL) && reg_wdata_i[0])
    |=> ##1 (active_base_o == relocated_base_o))
    else $error("relocated base not selected");

endmodule : scr_regs

`default_nettype wire

/* sim/scr_bus_master.sv */
// Register bus master model that drives the bank's access port.
// Assumes one-cycle strobes and an answer one cycle after the strobe edge.
`timescale 1ns/1ps
`default_nettype none
module scr_bus_master (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  output logic      [15:0] reg_offset_o,
  output logic             reg_write_o,
  output logic             reg_read_o,
  output logic             reg_is_d16_o,
  output logic      [15:0] reg_wdata_o
);
  // -----------------------------------------------------------------
  // Idle levels at time zero.
  // -----------------------------------------------------------------
  initial begin
    reg_offset_o = 16'h0000;
    reg_write_o  = 1'b0;
    reg_read_o   = 1'b0;
    reg_is_d16_o = 1'b1;
    reg_wdata_o  = 16'h0000;
  end

  // One access: strobe for a cycle, take the answer in the next one.
  // Released offset and data lines show the inverse so stale values cannot pass; strobes drop low.
  task automatic access(input logic wr, input logic d16, input logic [15:0] ofs,
                        input logic [15:0] wd, output logic [15:0] rd, output logic ack);
    @(negedge clk_sys_i);
    reg_offset_o = ofs;
    reg_wdata_o  = wd;
    reg_is_d16_o = d16;
    reg_write_o  = wr;
    reg_read_o   = ~wr;
    @(negedge clk_sys_i);
    rd           = reg_rdata_i;
    ack          = reg_ack_i;
    reg_write_o  = 1'b0;
    reg_read_o   = 1'b0;
    reg_offset_o = ~ofs;
    reg_wdata_o  = ~wd;
  endtask : access
endmodule : scr_bus_master
`default_nettype wire

/* sim/tb.sv */
// Self-checking bench for the scaler register bank.
// Assumes the bus master model owns the register port; status lines come from here.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    logic        wr;
    logic [15:0] ofs;
    logic [15:0] wd;
    logic [15:0] exp;
    logic        clr;
  } scr_row_type;
  logic        clk_sys_i, reset_i, wr, rd, d16, ack, irq_ack, has_d, c_rdy, c_bsy;
  logic        o_bsy, t_on, t_off, berr, a, aux_ack;
  logic [15:0] ofs, wdata, rdata, count, level, v, aux_rdata;
  int          n_mismatch, comparisons;
  scr_row_type rows [17];

  // -----------------------------------------------------------------
  // Clock, design and bus master.
  // -----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  scr_regs dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_offset_i(ofs),
    .reg_write_i(wr), .reg_read_i(rd), .reg_is_d16_i(d16), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_ack_o(ack), .irq_ack_i(irq_ack), .irq_vector_o(),
    .irq_level_o(), .irq_request_o(), .buf_word_count_i(count),
    .buf_has_data_flag_i(has_d), .almost_full_level_i(level), .chain_ready_i(c_rdy),
    .chain_busy_i(c_bsy), .own_busy_i(o_bsy), .term_all_on_i(t_on),
    .term_all_off_i(t_off), .bus_error_event_i(berr), .aux_slot_connector_i(5'h03),
    .rotary_base_i(5'h0A), .control_o(), .bus_error_allow_o(), .slot_number_o(),
    .relocated_base_o(), .relocation_on_o(), .broadcast_address_o(), .active_base_o(),
    .clear_data_o(), .clear_buffer_o(), .module_clear_o());
  scr_bus_master u_master (.clk_sys_i(clk_sys_i), .reg_rdata_i(rdata), .reg_ack_i(ack),
    .reg_offset_o(ofs), .reg_write_o(wr), .reg_read_o(rd), .reg_is_d16_o(d16),
    .reg_wdata_o(wdata));
  // Build with the aux connector, fed the same traffic, for the slot rules.
  scr_regs #(.HAS_AUX_CONNECTOR(1'b1)) dut_aux (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .reg_offset_i(ofs), .reg_write_i(wr), .reg_read_i(rd), .reg_is_d16_i(d16),
    .reg_wdata_i(wdata), .reg_rdata_o(aux_rdata), .reg_ack_o(aux_ack), .irq_ack_i(irq_ack),
    .irq_vector_o(), .irq_level_o(), .irq_request_o(), .buf_word_count_i(count),
    .buf_has_data_flag_i(has_d), .almost_full_level_i(level), .chain_ready_i(c_rdy),
    .chain_busy_i(c_bsy), .own_busy_i(o_bsy), .term_all_on_i(t_on),
    .term_all_off_i(t_off), .bus_error_event_i(berr), .aux_slot_connector_i(5'h03),
    .rotary_base_i(5'h0A), .control_o(), .bus_error_allow_o(), .slot_number_o(),
    .relocated_base_o(), .relocation_on_o(), .broadcast_address_o(), .active_base_o(),
    .clear_data_o(), .clear_buffer_o(), .module_clear_o());

  // -----------------------------------------------------------------
  // Checking and closing.
  // -----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Mismatches %0d in %0d comparisons", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // The whole run needs well under ten thousand cycles.
  initial begin
    #100_000;
    n_mismatch++;
    report_and_stop();
  end

  // -----------------------------------------------------------------
  // Main sequence: table of plain accesses, then the awkward cases.
  // -----------------------------------------------------------------
  initial begin
    reset_i = 1'b1;
    {irq_ack, has_d, c_rdy, c_bsy, o_bsy, t_on, t_off, berr} = 8'h00;
    count = 16'h0000;
    level = scr_pkg::ALMOST_FULL_RESET;
    n_mismatch = 0;
    comparisons = 0;
    rows = '{'{1, 16'h110A, 16'h0010, 16'h0010, 1}, '{1, 16'h110A, 16'h00A5, 16'h00B5, 1},
             '{1, 16'h110C, 16'h0010, 16'h00A5, 1}, '{1, 16'h110C, 16'h0000, 16'h00A5, 1},
             '{1, 16'h1112, 16'hFFFF, 16'h00A5, 0}, '{0, 16'h1112, 16'h0000, 16'h0007, 0},
             '{1, 16'h1114, 16'h1234, 16'h00A5, 0}, '{0, 16'h1114, 16'h0000, 16'h0034, 0},
             '{1, 16'h1116, 16'h00C3, 16'h00A5, 0}, '{1, 16'h1118, 16'h005A, 16'h00A5, 0},
             '{0, 16'h1116, 16'h0000, 16'h00C3, 0}, '{0, 16'h1118, 16'h0000, 16'h005A, 0},
             '{1, 16'h111C, 16'h0055, 16'h00A5, 1}, '{0, 16'h111C, 16'h0000, 16'h0055, 0},
             '{1, 16'h1110, 16'h0007, 16'h00A5, 1}, '{0, 16'h1110, 16'h0000, 16'h0007, 0},
             '{0, 16'h1200, 16'h0000, 16'h0000, 0}};
    repeat (8) @(negedge clk_sys_i);
    reset_i = 1'b0;
    // Writes check control bits and clear strobes; reads check the data.
    foreach (rows[i]) begin
      u_master.access(rows[i].wr, 1'b1, rows[i].ofs, rows[i].wd, v, a);
      chk("ack", 16'h0001, {15'h0, a});
      if (rows[i].wr) begin
        chk("clear_data", {15'h0, rows[i].clr}, {15'h0, dut.clear_data_o});
        chk("clear_buffer", {15'h0, rows[i].clr}, {15'h0, dut.clear_buffer_o});
        chk("mclr", {15'h0, rows[i].ofs == 16'h1110}, {15'h0, dut.module_clear_o});
        @(negedge clk_sys_i);
        chk("control", rows[i].exp, {8'h00, dut.control_o});
        chk("allow", {15'h0, rows[i].exp[4]}, {15'h0, dut.bus_error_allow_o});
      end else begin
        chk("rdata", rows[i].exp, v);
      end
    end
    // The aux build leaves slot writes unanswered and reads its connector.
    u_master.access(1'b1, 1'b1, 16'h1110, 16'h0007, v, a);
    chk("aux_slot_ack", 16'h0000, {15'h0, aux_ack});
    u_master.access(1'b0, 1'b1, 16'h1110, 16'h0000, v, a);
    chk("aux_slot", 16'h0003, aux_rdata);
    chk("berr_allow", 16'h0000, {15'h0, dut.bus_error_allow_o});
    // An alias write without a 16-bit cycle is acked but changes nothing.
    u_master.access(1'b1, 1'b0, 16'h110A, 16'h0040, v, a);
    chk("ack_d32", 16'h0001, {15'h0, a});
    @(negedge clk_sys_i);
    chk("control_d32", 16'h00A5, {8'h00, dut.control_o});
    chk("base_switch", 16'h5000, dut.active_base_o);
    u_master.access(1'b1, 1'b1, 16'h111A, 16'h0001, v, a);
    @(negedge clk_sys_i);
    chk("base_reloc", 16'hC35A, dut.active_base_o);
    chk("reloc_base", 16'hC35A, dut.relocated_base_o);
    chk("reloc_on", 16'h0001, {15'h0, dut.relocation_on_o});
    chk("slot_kept", 16'h0007, {11'h0, dut.slot_number_o});
    // Almost-full and full thresholds, straddling each boundary.
    {has_d, o_bsy, t_on, c_rdy} = 4'hF;
    foreach (rows[i]) begin
      if (i < 4) begin
        count = (i < 2) ? 16'd63 + 16'(i) : 16'd32734 + 16'(i - 2);
        u_master.access(1'b0, 1'b1, 16'h110E, 16'h0000, v, a);
        chk("status", 16'h0039 | (count >= 64 ? 16'h2 : 16'h0)
            | (count >= 32768 - 33 ? 16'h4 : 16'h0), v);
      end
    end
    chk("irq_on", 16'h0001, {15'h0, dut.irq_request_o});
    u_master.access(1'b1, 1'b1, 16'h1112, 16'h0000, v, a);
    repeat (2) @(negedge clk_sys_i);
    chk("irq_off", 16'h0000, {15'h0, dut.irq_request_o});
    // Chain busy alone, all terminations off, then a bus error cleared by reading.
    {has_d, o_bsy, t_on, c_rdy, c_bsy, t_off} = 6'b000011;
    count = 16'h0000;
    berr = 1'b1;
    @(negedge clk_sys_i);
    berr = 1'b0;
    u_master.access(1'b0, 1'b1, 16'h110E, 16'h0000, v, a);
    chk("status_berr", 16'h00D0, v);
    u_master.access(1'b0, 1'b1, 16'h110E, 16'h0000, v, a);
    chk("status_clr", 16'h0050, v);
    // Interrupt acknowledge presents the vector on the data lines.
    irq_ack = 1'b1;
    @(negedge clk_sys_i);
    irq_ack = 1'b0;
    chk("vector", 16'h0034, {8'h00, rdata[7:0]});
    // A reset in mid-run restores every default.
    reset_i = 1'b1;
    @(negedge clk_sys_i);
    reset_i = 1'b0;
    @(negedge clk_sys_i);
    chk("rst_control", 16'h0000, {8'h00, dut.control_o});
    chk("rst_vector", 16'h00DD, {8'h00, dut.irq_vector_o});
    chk("rst_level", 16'h0000, {13'h0, dut.irq_level_o});
    chk("rst_bcast", 16'h00AA, {8'h00, dut.broadcast_address_o});
    chk("rst_slot", 16'h001F, {11'h0, dut.slot_number_o});
    chk("rst_reloc", 16'h0000, {15'h0, dut.relocation_on_o});
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
